// ### hw/uirsc_ctrl.sv
// Reset, interrupt identification and sleep control of one UART channel.
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
module uirsc_ctrl
  import uirsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic hw_reset_n,
  input wire logic [4:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic rx_pin,
  input wire logic [3:0] modem_n,
  input wire logic [7:0] gpio_in,
  input wire uirsc_dp_in_type dp_in,
  output uirsc_dp_out_type dp_out,
  output uirsc_cfg_type cfg,
  output logic tx_pin,
  output logic rts_n,
  output logic [7:0] gpio_out,
  output logic [7:0] gpio_oe_n,
  output logic irq_out,
  output logic irq_oe_n,
  output logic uart_clk_en,
  output logic sleeping
);

  // Picks the identification code of the most urgent pending source.
  function automatic logic [5:0] ident_code(input logic [7:0] pend);
    logic [5:0] code;
    code = ID_NONE;
    if (pend[0]) begin
      code = ID_LSTAT;
    end else if (pend[1]) begin
      code = ID_TOUT;
    end else if (pend[2]) begin
      code = ID_RXRDY;
    end else if (pend[3]) begin
      code = ID_THR;
    end else if (pend[4]) begin
      code = ID_MODEM;
    end else if (pend[5]) begin
      code = ID_GPIO;
    end else if (pend[6]) begin
      code = ID_XOFF;
    end else if (pend[7]) begin
      code = ID_FLOW;
    end
    return code;
  endfunction

  logic [13:0] sync1_reg;
  logic [13:0] sync2_reg;
  logic [13:0] prev_reg;
  logic soft_rst_reg;
  logic any_rst;
  logic wr_hit;
  logic rd_hit;
  logic [7:0] ien_reg;
  logic [7:0] fcr_reg;
  logic [7:0] lcr_reg;
  logic [7:0] mcr_reg;
  logic [7:0] efr_reg;
  logic [7:0] tcr_reg;
  logic [7:0] tlr_reg;
  logic [7:0] iodir_reg;
  logic [7:0] ioien_reg;
  logic [7:0] ioctrl_reg;
  logic [7:0] efcr_reg;
  logic [7:0] iostate_reg;
  logic [7:0] dll_reg;
  logic [7:0] dlh_reg;
  logic [7:0] spr_reg;
  logic [7:0] flow_on_char_one_reg;
  logic [7:0] flow_on_char_two_reg;
  logic [7:0] flow_off_char_one_reg;
  logic [7:0] flow_off_char_two_reg;
  logic [7:0] lsr_reg;
  logic [7:0] lsr_next;
  logic [7:0] ident_reg;
  logic [7:0] txlvl_reg;
  logic [7:0] rxlvl_reg;
  logic [3:0] msr_delta_reg;
  logic [7:0] io_chg_reg;
  logic overrun_reg;
  logic xoff_flag_reg;
  logic special_flag_reg;
  logic rts_flag_reg;
  logic cts_flag_reg;
  logic rts_n_reg;
  logic rts_n_prev_reg;
  logic tx_pin_reg;
  logic irq_oe_n_reg;
  logic sleep_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] pend;
  logic pend_no_thr;
  logic sleep_ok;
  logic wake;
  logic tx_push_reg;
  logic [7:0] tx_data_reg;
  logic rx_pop_reg;
  logic rx_clr_reg;
  logic tx_clr_reg;
  logic rx_s;
  logic [3:0] modem_s;
  logic [7:0] gpio_s;
  logic [3:0] modem_p;
  logic [7:0] gpio_p;

  // Two-stage synchronisers for the pins; they run through reset, so the
  // change detectors see no false edge when reset ends.
  always_ff @(posedge sys_clk) begin
    sync1_reg <= {hw_reset_n, rx_pin, modem_n, gpio_in};
    sync2_reg <= sync1_reg;
    prev_reg <= sync2_reg;
  end

  // Synchronised pin levels and their previous samples.
  assign rx_s = sync2_reg[12];
  assign modem_s = sync2_reg[11:8];
  assign gpio_s = sync2_reg[7:0];
  assign modem_p = prev_reg[11:8];
  assign gpio_p = prev_reg[7:0];

  // All three reset sources act alike, except that only srst clears the read data register.
  assign any_rst = srst | ~sync2_reg[13] | soft_rst_reg;
  assign wr_hit = bus_wr;
  assign rd_hit = bus_rd;

  // Software reset is a one-cycle pulse written by the host.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= wr_hit && bus_addr == A_SWRST && bus_wdata[SWRST_BIT];
    end
  end

  // Control registers that every reset clears, except LCR, which every reset loads with LCR_RST.
  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      ien_reg <= ZERO8;
      fcr_reg <= ZERO8;
      lcr_reg <= LCR_RST;
      mcr_reg <= ZERO8;
      efr_reg <= ZERO8;
      tcr_reg <= ZERO8;
      tlr_reg <= ZERO8;
      iodir_reg <= ZERO8;
      ioien_reg <= ZERO8;
      ioctrl_reg <= ZERO8;
      efcr_reg <= ZERO8;
      iostate_reg <= ZERO8;
    end else if (wr_hit) begin
      unique case (bus_addr)
        A_IEN: ien_reg <= bus_wdata;
        A_IDENT: fcr_reg <= bus_wdata;
        A_LCR: lcr_reg <= bus_wdata;
        A_MCR: mcr_reg <= bus_wdata;
        A_EFR: efr_reg <= bus_wdata;
        A_TCR: tcr_reg <= bus_wdata;
        A_TLR: tlr_reg <= bus_wdata;
        A_IODIR: iodir_reg <= bus_wdata;
        A_IOIEN: ioien_reg <= bus_wdata;
        A_IOCTRL: ioctrl_reg <= bus_wdata;
        A_EFCR: efcr_reg <= bus_wdata;
        A_IOSTATE: iostate_reg <= bus_wdata;
        default: ;
      endcase
    end
  end

  // Divisor, scratchpad and flow characters keep their contents over reset.
  always_ff @(posedge sys_clk) begin
    if (wr_hit) begin
      unique case (bus_addr)
        A_DLL: dll_reg <= bus_wdata;
        A_DLH: dlh_reg <= bus_wdata;
        A_SPR: spr_reg <= bus_wdata;
        A_FLOW_ON_CHAR_ONE: flow_on_char_one_reg <= bus_wdata;
        A_FLOW_ON_CHAR_TWO: flow_on_char_two_reg <= bus_wdata;
        A_FLOW_OFF_CHAR_ONE: flow_off_char_one_reg <= bus_wdata;
        A_FLOW_OFF_CHAR_TWO: flow_off_char_two_reg <= bus_wdata;
        default: ;
      endcase
    end
  end

  // Strobes toward the datapath; reset also clears the FIFO pointers.
  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      tx_push_reg <= 1'b0;
      tx_data_reg <= ZERO8;
      rx_pop_reg <= 1'b0;
      rx_clr_reg <= 1'b1;
      tx_clr_reg <= 1'b1;
    end else begin
      tx_push_reg <= wr_hit && bus_addr == A_HOLD;
      tx_data_reg <= (wr_hit && bus_addr == A_HOLD) ? bus_wdata : tx_data_reg;
      rx_pop_reg <= rd_hit && bus_addr == A_HOLD;
      rx_clr_reg <= wr_hit && bus_addr == A_IDENT && bus_wdata[FCR_RXCLR];
      tx_clr_reg <= wr_hit && bus_addr == A_IDENT && bus_wdata[FCR_TXCLR];
    end
  end

  // Overrun is sticky until line status is read; a new overrun wins.
  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      overrun_reg <= 1'b0;
    end else if (dp_in.overrun) begin
      overrun_reg <= 1'b1;
    end else if (rd_hit && bus_addr == A_LSR) begin
      overrun_reg <= 1'b0;
    end
  end

  // Line status value presented to the host.
  always_comb begin
    lsr_next = ZERO8;
    lsr_next[7] = dp_in.rx_err_in_fifo;
    lsr_next[6] = dp_in.tx_empty & dp_in.tx_shift_empty;
    lsr_next[5] = dp_in.tx_empty;
    lsr_next[4:2] = dp_in.rx_empty ? 3'h0 : dp_in.head_err;
    lsr_next[1] = overrun_reg;
    lsr_next[0] = ~dp_in.rx_empty;
  end

  // Line status and FIFO levels are registered so reset values are exact.
  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      lsr_reg <= LSR_RST;
      txlvl_reg <= TXLVL_RST;
      rxlvl_reg <= ZERO8;
    end else begin
      lsr_reg <= lsr_next;
      txlvl_reg <= dp_in.tx_level;
      rxlvl_reg <= dp_in.rx_level;
    end
  end

  // Modem deltas: any pin change sets, a status read clears, set wins.
  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      msr_delta_reg <= 4'h0;
    end else if (rd_hit && bus_addr == A_MSR) begin
      msr_delta_reg <= modem_s ^ modem_p;
    end else begin
      msr_delta_reg <= msr_delta_reg | (modem_s ^ modem_p);
    end
  end

  // GPIO input changes on pins set as inputs; cleared by reading the pins.
  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      io_chg_reg <= ZERO8;
    end else if (rd_hit && bus_addr == A_IOSTATE) begin
      io_chg_reg <= (gpio_s ^ gpio_p) & ~iodir_reg;
    end else begin
      io_chg_reg <= io_chg_reg | ((gpio_s ^ gpio_p) & ~iodir_reg);
    end
  end

  // Flow-off cause is cleared by flow-on detection, set wins.
  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      xoff_flag_reg <= 1'b0;
    end else if (dp_in.xoff_det) begin
      xoff_flag_reg <= 1'b1;
    end else if (dp_in.xon_det) begin
      xoff_flag_reg <= 1'b0;
    end
  end

  // Special character cause is cleared by reading identification.
  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      special_flag_reg <= 1'b0;
    end else if (dp_in.special_det) begin
      special_flag_reg <= 1'b1;
    end else if (rd_hit && bus_addr == A_IDENT) begin
      special_flag_reg <= 1'b0;
    end
  end

  // RTS or CTS going inactive high; cleared by a modem status read.
  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      rts_flag_reg <= 1'b0;
      cts_flag_reg <= 1'b0;
    end else begin
      if (rts_n_reg & ~rts_n_prev_reg) begin
        rts_flag_reg <= 1'b1;
      end else if (rd_hit && bus_addr == A_MSR) begin
        rts_flag_reg <= 1'b0;
      end
      if (modem_s[0] & ~modem_p[0]) begin
        cts_flag_reg <= 1'b1;
      end else if (rd_hit && bus_addr == A_MSR) begin
        cts_flag_reg <= 1'b0;
      end
    end
  end

  // Pending sources, each gated by an enable; timeout and receive ready share IEN_RX, GPIO uses ioien_reg.
  always_comb begin
    pend = ZERO8;
    pend[0] = ien_reg[IEN_LS] & (dp_in.rx_err_in_fifo | overrun_reg);
    pend[1] = ien_reg[IEN_RX] & dp_in.rx_timeout;
    pend[2] = ien_reg[IEN_RX] & dp_in.rx_ready;
    pend[3] = ien_reg[IEN_THR] & dp_in.thr_req;
    pend[4] = ien_reg[IEN_MS] & (|msr_delta_reg);
    pend[5] = |(io_chg_reg & ioien_reg);
    pend[6] = ien_reg[IEN_XOFF] & (xoff_flag_reg | special_flag_reg);
    pend[7] = (ien_reg[IEN_RTS] & rts_flag_reg) |
              (ien_reg[IEN_CTS] & cts_flag_reg);
  end

  // Identification register and the open-drain interrupt enable.
  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      ident_reg <= IDENT_RST;
      irq_oe_n_reg <= 1'b1;
    end else begin
      ident_reg <= {{2{fcr_reg[FCR_EN]}}, ident_code(pend)};
      irq_oe_n_reg <= ~(|pend);
    end
  end

  // Serial output and RTS pin levels.
  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      tx_pin_reg <= 1'b1;
      rts_n_reg <= 1'b1;
      rts_n_prev_reg <= 1'b1;
    end else begin
      tx_pin_reg <= dp_in.tx_bit & ~lcr_reg[LCR_BRK];
      rts_n_reg <= ~mcr_reg[MCR_RTS];
      rts_n_prev_reg <= rts_n_reg;
    end
  end

  // Sleep entry conditions and wake events.
  assign pend_no_thr = |(pend & ~(8'h01 << PEND_THR));
  assign sleep_ok = efr_reg[EFR_ENH] & ien_reg[IEN_SLEEP];
  assign wake = (rx_s != prev_reg[12]) | (|(modem_s ^ modem_p)) |
                (wr_hit && bus_addr == A_HOLD) | ~sleep_ok;

  // Sleep state; the UART clock stops while it is set. A push still in
  // flight counts as transmit data, as the FIFO shows it a cycle late.
  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      sleep_reg <= 1'b0;
    end else if (sleep_reg) begin
      sleep_reg <= ~wake;
    end else begin
      sleep_reg <= sleep_ok & rx_s & dp_in.tx_empty & dp_in.tx_shift_empty &
                   ~tx_push_reg & ~pend_no_thr & dp_in.rx_empty &
                   ~wake;
    end
  end

  // Read multiplexer for the register port.
  always_comb begin
    rdata_next = ZERO8;
    unique case (bus_addr)
      A_HOLD: rdata_next = dp_in.rx_data;
      A_IEN: rdata_next = ien_reg;
      A_IDENT: rdata_next = ident_reg;
      A_LCR: rdata_next = lcr_reg;
      A_MCR: rdata_next = mcr_reg;
      A_LSR: rdata_next = lsr_reg;
      A_MSR: rdata_next = {~modem_s, msr_delta_reg};
      A_SPR: rdata_next = spr_reg;
      A_TCR: rdata_next = tcr_reg;
      A_TLR: rdata_next = tlr_reg;
      A_TXLVL: rdata_next = txlvl_reg;
      A_RXLVL: rdata_next = rxlvl_reg;
      A_IODIR: rdata_next = iodir_reg;
      A_IOSTATE: rdata_next = gpio_s;
      A_IOIEN: rdata_next = ioien_reg;
      A_IOCTRL: rdata_next = ioctrl_reg;
      A_EFCR: rdata_next = efcr_reg;
      A_DLL: rdata_next = dll_reg;
      A_DLH: rdata_next = dlh_reg;
      A_EFR: rdata_next = efr_reg;
      A_FLOW_ON_CHAR_ONE: rdata_next = flow_on_char_one_reg;
      A_FLOW_ON_CHAR_TWO: rdata_next = flow_on_char_two_reg;
      A_FLOW_OFF_CHAR_ONE: rdata_next = flow_off_char_one_reg;
      A_FLOW_OFF_CHAR_TWO: rdata_next = flow_off_char_two_reg;
      default: rdata_next = ZERO8;
    endcase
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_reg <= ZERO8;
    end else begin
      rdata_reg <= rd_hit ? rdata_next : ZERO8;
    end
  end

  // Output assignments.
  assign bus_rdata = rdata_reg;
  assign dp_out.tx_push = tx_push_reg;
  assign dp_out.tx_data = tx_data_reg;
  assign dp_out.rx_pop = rx_pop_reg;
  assign dp_out.rx_fifo_clr = rx_clr_reg;
  assign dp_out.tx_fifo_clr = tx_clr_reg;
  assign cfg.fifo_ctrl = fcr_reg;
  assign cfg.line_ctrl = lcr_reg;
  assign cfg.modem_ctrl = mcr_reg;
  assign cfg.enh_feat = efr_reg;
  assign cfg.flow_thr = tcr_reg;
  assign cfg.fifo_trig = tlr_reg;
  assign cfg.io_ctrl = ioctrl_reg;
  assign cfg.extra_feat = efcr_reg;
  assign cfg.divisor = {dlh_reg, dll_reg};
  assign cfg.xon_one = flow_on_char_one_reg;
  assign cfg.xon_two = flow_on_char_two_reg;
  assign cfg.xoff_one = flow_off_char_one_reg;
  assign cfg.xoff_two = flow_off_char_two_reg;
  assign tx_pin = tx_pin_reg;
  assign rts_n = rts_n_reg;
  assign gpio_out = iostate_reg;
  assign gpio_oe_n = ~iodir_reg;
  assign irq_out = 1'b0;
  assign irq_oe_n = irq_oe_n_reg;
  assign uart_clk_en = ~sleep_reg;
  assign sleeping = sleep_reg;

endmodule

// ### hw/uirsc_pkg.sv
// Constants, register map and carrier types of the UART interrupt, reset and sleep control.
package uirsc_pkg;

  // Register offsets on the local register port.
  localparam logic [4:0] A_HOLD = 5'h00;
  localparam logic [4:0] A_IEN = 5'h01;
  localparam logic [4:0] A_IDENT = 5'h02;
  localparam logic [4:0] A_LCR = 5'h03;
  localparam logic [4:0] A_MCR = 5'h04;
  localparam logic [4:0] A_LSR = 5'h05;
  localparam logic [4:0] A_MSR = 5'h06;
  localparam logic [4:0] A_SPR = 5'h07;
  localparam logic [4:0] A_TCR = 5'h08;
  localparam logic [4:0] A_TLR = 5'h09;
  localparam logic [4:0] A_TXLVL = 5'h0a;
  localparam logic [4:0] A_RXLVL = 5'h0b;
  localparam logic [4:0] A_IODIR = 5'h0c;
  localparam logic [4:0] A_IOSTATE = 5'h0d;
  localparam logic [4:0] A_IOIEN = 5'h0e;
  localparam logic [4:0] A_IOCTRL = 5'h0f;
  localparam logic [4:0] A_EFCR = 5'h10;
  localparam logic [4:0] A_DLL = 5'h11;
  localparam logic [4:0] A_DLH = 5'h12;
  localparam logic [4:0] A_EFR = 5'h13;
  localparam logic [4:0] A_FLOW_ON_CHAR_ONE = 5'h14;
  localparam logic [4:0] A_FLOW_ON_CHAR_TWO = 5'h15;
  localparam logic [4:0] A_FLOW_OFF_CHAR_ONE = 5'h16;
  localparam logic [4:0] A_FLOW_OFF_CHAR_TWO = 5'h17;
  localparam logic [4:0] A_SWRST = 5'h18;

  // Reset values.
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [7:0] LCR_RST = 8'h1d;
  localparam logic [7:0] LSR_RST = 8'h60;
  localparam logic [7:0] IDENT_RST = 8'h01;
  localparam logic [7:0] TXLVL_RST = 8'h40;
  localparam logic [13:0] SYNC_RST = 14'h3fff;

  // Interrupt identification codes.
  localparam logic [5:0] ID_NONE = 6'h01;
  localparam logic [5:0] ID_LSTAT = 6'h06;
  localparam logic [5:0] ID_TOUT = 6'h0c;
  localparam logic [5:0] ID_RXRDY = 6'h04;
  localparam logic [5:0] ID_THR = 6'h02;
  localparam logic [5:0] ID_MODEM = 6'h00;
  localparam logic [5:0] ID_GPIO = 6'h30;
  localparam logic [5:0] ID_XOFF = 6'h10;
  localparam logic [5:0] ID_FLOW = 6'h20;

  // Field positions.
  localparam int IEN_RX = 0;
  localparam int IEN_THR = 1;
  localparam int IEN_LS = 2;
  localparam int IEN_MS = 3;
  localparam int IEN_SLEEP = 4;
  localparam int IEN_XOFF = 5;
  localparam int IEN_RTS = 6;
  localparam int IEN_CTS = 7;
  localparam int EFR_ENH = 4;
  localparam int LCR_BRK = 6;
  localparam int MCR_RTS = 1;
  localparam int FCR_EN = 0;
  localparam int FCR_RXCLR = 1;
  localparam int FCR_TXCLR = 2;
  localparam int SWRST_BIT = 0;
  localparam int PEND_THR = 3;

  // Status from the character datapath.
  typedef struct packed {
    logic rx_err_in_fifo;
    logic [2:0] head_err;
    logic overrun;
    logic rx_timeout;
    logic rx_ready;
    logic thr_req;
    logic xoff_det;
    logic xon_det;
    logic special_det;
    logic rx_empty;
    logic tx_empty;
    logic tx_shift_empty;
    logic tx_bit;
    logic [7:0] rx_data;
    logic [7:0] tx_level;
    logic [7:0] rx_level;
  } uirsc_dp_in_type;

  // Strobes and data toward the character datapath.
  typedef struct packed {
    logic tx_push;
    logic [7:0] tx_data;
    logic rx_pop;
    logic rx_fifo_clr;
    logic tx_fifo_clr;
  } uirsc_dp_out_type;

  // Configuration held for the datapath.
  typedef struct packed {
    logic [7:0] fifo_ctrl;
    logic [7:0] line_ctrl;
    logic [7:0] modem_ctrl;
    logic [7:0] enh_feat;
    logic [7:0] flow_thr;
    logic [7:0] fifo_trig;
    logic [7:0] io_ctrl;
    logic [7:0] extra_feat;
    logic [15:0] divisor;
    logic [7:0] xon_one;
    logic [7:0] xon_two;
    logic [7:0] xoff_one;
    logic [7:0] xoff_two;
  } uirsc_cfg_type;

endpackage

// ### tb/uirsc_ctrl_assertions.sv
// Concurrent checks on the ports of the UART reset, interrupt and sleep block.
`timescale 1ns/1ps
module uirsc_ctrl_checker
  import uirsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic hw_reset_n,
  input wire logic [4:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic rx_pin,
  input wire uirsc_dp_in_type dp_in,
  input wire uirsc_dp_out_type dp_out,
  input wire uirsc_cfg_type cfg,
  input wire logic tx_pin,
  input wire logic rts_n,
  input wire logic [7:0] gpio_oe_n,
  input wire logic irq_out,
  input wire logic irq_oe_n,
  input wire logic uart_clk_en,
  input wire logic sleeping
);
  // All checks run on the system clock and pause while the system reset srst is applied.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  // Reset sources idle the pins; checked are all after system reset, all but TX after soft reset, all but the interrupt line after the reset pin.
  a_reset_pins: assert property (
    $fell(srst) |-> tx_pin && rts_n && gpio_oe_n == 8'hff && irq_oe_n)
    else $error("pins not idle after system reset");
  a_soft_reset: assert property (
    bus_wr && bus_addr == A_SWRST && bus_wdata[SWRST_BIT] |->
    ##[1:3] (rts_n && gpio_oe_n == 8'hff && irq_oe_n))
    else $error("soft reset did not idle the pins");
  a_hw_reset: assert property (
    $fell(hw_reset_n) |-> ##[2:5] (tx_pin && rts_n && gpio_oe_n == 8'hff))
    else $error("reset pin did not idle the pins");
  // The identification code agrees with the state of the interrupt line.
  a_ident_none: assert property (
    bus_rd && bus_addr == A_IDENT && irq_oe_n && $past(irq_oe_n) |=>
    bus_rdata[5:0] == ID_NONE)
    else $error("idle line but identification shows a source");
  a_ident_pend: assert property (
    bus_rd && bus_addr == A_IDENT && !irq_oe_n && !$past(irq_oe_n) |=>
    bus_rdata[5:0] != ID_NONE)
    else $error("line pulled low but no source identified");
  a_irq_drain: assert property (irq_out == 1'b0)
    else $error("interrupt pin driven high");
  // Sleep gating, entry conditions and wake-up.
  a_clk_gate: assert property (uart_clk_en == !sleeping)
    else $error("uart clock enable disagrees with sleep");
  a_sleep_entry: assert property (
    $rose(sleeping) |-> cfg.enh_feat[EFR_ENH] && $past(dp_in.rx_empty) &&
    $past(dp_in.tx_empty) && $past(dp_in.tx_shift_empty) && $past(rx_pin))
    else $error("sleep entered while not allowed");
  a_sleep_perm: assert property (
    !cfg.enh_feat[EFR_ENH] |=> !sleeping)
    else $error("asleep without enhanced functions");
  a_wake_write: assert property (
    sleeping && bus_wr && bus_addr == A_HOLD |=>
    !sleeping && dp_out.tx_push && dp_out.tx_data == $past(bus_wdata))
    else $error("transmit write did not wake");
  a_wake_rx: assert property (
    sleeping && $changed(rx_pin) |-> ##[1:6] !sleeping)
    else $error("receive line activity did not wake");

  c_sleep: cover property ($rose(sleeping));
  c_irq: cover property ($fell(irq_oe_n));
  c_soft: cover property (bus_wr && bus_addr == A_SWRST);
endmodule

bind uirsc_ctrl uirsc_ctrl_checker u_checker (
  .sys_clk(sys_clk), .srst(srst), .hw_reset_n(hw_reset_n),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_rdata(bus_rdata), .rx_pin(rx_pin),
  .dp_in(dp_in), .dp_out(dp_out), .cfg(cfg), .tx_pin(tx_pin),
  .rts_n(rts_n), .gpio_oe_n(gpio_oe_n), .irq_out(irq_out),
  .irq_oe_n(irq_oe_n), .uart_clk_en(uart_clk_en), .sleeping(sleeping)
);

// ### tb/uirsc_ctrl_tb_top.sv
// Self-checking bench for the UART reset, interrupt and sleep block.
`timescale 1ns/1ps
module uirsc_ctrl_tb_top import uirsc_pkg::*;;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic hw_reset_n = 1'b1;
  logic [4:0] bus_addr = 5'h00;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic rx_pin = 1'b1;
  logic [3:0] modem_n = 4'hf;
  logic [7:0] gpio_in = 8'h00;
  logic [5:0] ev = 6'h00;
  logic [7:0] bus_rdata, gpio_out, gpio_oe_n;
  logic tx_pin, rts_n, irq_out, irq_oe_n, uart_clk_en, sleeping;
  uirsc_dp_in_type dp_in;
  uirsc_dp_out_type dp_out;
  uirsc_cfg_type cfg;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [4:0] rst_a [14] = '{A_IEN, A_IDENT, A_LCR, A_MCR, A_LSR, A_TCR,
    A_TLR, A_TXLVL, A_RXLVL, A_IODIR, A_IOIEN, A_IOCTRL, A_EFCR, A_EFR};
  logic [7:0] rst_v [14] = '{8'h00, 8'h01, 8'h1d, 8'h00, 8'h60, 8'h00,
    8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [4:0] pre_a [15] = '{A_IEN, A_LCR, A_MCR, A_TCR, A_TLR, A_IODIR,
    A_IOIEN, A_EFCR, A_DLL, A_DLH, A_SPR, A_FLOW_ON_CHAR_ONE, A_FLOW_ON_CHAR_TWO, A_FLOW_OFF_CHAR_ONE, A_FLOW_OFF_CHAR_TWO};
  logic [3:0] lv [5] = '{4'hf, 4'he, 4'ha, 4'h8, 4'h0};
  logic [7:0] id [5] = '{8'h06, 8'h0c, 8'h04, 8'h02, 8'h10};

  uirsc_ctrl DUT (.sys_clk(sys_clk), .srst(srst), .hw_reset_n(hw_reset_n),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .rx_pin(rx_pin),
    .modem_n(modem_n), .gpio_in(gpio_in), .dp_in(dp_in), .dp_out(dp_out),
    .cfg(cfg), .tx_pin(tx_pin), .rts_n(rts_n), .gpio_out(gpio_out),
    .gpio_oe_n(gpio_oe_n), .irq_out(irq_out), .irq_oe_n(irq_oe_n),
    .uart_clk_en(uart_clk_en), .sleeping(sleeping));
  uirsc_dp_model u_dp (.sys_clk(sys_clk), .ev(ev), .dp_out(dp_out),
    .dp_in(dp_in));

  // Clock at 40 MHz.
  always #12.5 sys_clk = ~sys_clk;

  // Cuts a hung run short.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      close_out();
    end
  end

  // Prints the verdict and ends the run.
  task automatic close_out();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Compares one value and reports a difference at once.
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // Register write and checked read on the local port.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1;
    chk($sformatf("reg_%h", a), e, bus_rdata);
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Registers, pins and the modem status after any reset.
  task automatic t_check_reset();
    for (int i = 0; i < 14; i++) begin
      rdc(rst_a[i], rst_v[i]);
    end
    rdc(A_MSR, {~modem_n, 4'h0});
    rdc(5'h1f, 8'h00);
    chk("fifo_ctrl", 8'h00, cfg.fifo_ctrl);
    chk("out_pins", 8'h07, {5'h00, tx_pin, rts_n, irq_oe_n});
    chk("gpio_oe_n", 8'hff, gpio_oe_n);
  endtask

  // Soft reset, then the reset pin, each over registers full of data.
  task automatic t_reset_sources();
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 15; i++) begin
        wr(pre_a[i], 8'((i + 1) * 17));
      end
      @(posedge sys_clk);
      modem_n <= (k == 0) ? 4'h5 : 4'ha;
      wait_clk(6);
      if (k == 0) begin
        wr(A_SWRST, 8'h01);
      end else begin
        @(posedge sys_clk);
        hw_reset_n <= 1'b0;
        wait_clk(4);
        chk("fifo_clr", 8'h03,
            {6'h00, dp_out.rx_fifo_clr, dp_out.tx_fifo_clr});
        hw_reset_n <= 1'b1;
      end
      wait_clk(6);
      t_check_reset();
      for (int i = 8; i < 15; i++) begin
        rdc(pre_a[i], 8'((i + 1) * 17));
      end
    end
  endtask

  // Masked sources stay quiet; enabled ones are reported by priority.
  task automatic t_irq_prio();
    @(posedge sys_clk);
    ev <= 6'h1f;
    @(posedge sys_clk);
    ev[4] <= 1'b0;
    wait_clk(3);
    rdc(A_IDENT, 8'h01);
    chk("irq_oe_n", 8'h01, {7'h00, irq_oe_n});
    rdc(A_LSR, 8'he9);
    wr(A_IEN, 8'h27);
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      ev[3:0] <= lv[i];
      wait_clk(3);
      rdc(A_IDENT, id[i]);
      chk("irq_oe_n", 8'h00, {7'h00, irq_oe_n});
    end
    rdc(A_LSR, 8'h60);
    @(posedge sys_clk);
    ev[5] <= 1'b1;
    @(posedge sys_clk);
    ev[5] <= 1'b0;
    wait_clk(3);
    rdc(A_IDENT, 8'h01);
    chk("irq_oe_n", 8'h01, {7'h00, irq_oe_n});
    @(posedge sys_clk);
    ev[5:4] <= 2'b11;
    @(posedge sys_clk);
    ev[5:4] <= 2'b00;
    wait_clk(3);
    rdc(A_IDENT, 8'h10);
    rdc(A_IDENT, 8'h01);
  endtask

  // Modem, GPIO and clear-to-send pin changes and their clearing reads.
  task automatic t_pin_events();
    wr(A_IOSTATE, 8'h3c);
    #1;
    chk("gpio_out", 8'h3c, gpio_out);
    wr(A_IEN, 8'h08);
    @(posedge sys_clk);
    modem_n[1] <= ~modem_n[1];
    wait_clk(6);
    rdc(A_IDENT, 8'h00);
    rdc(A_MSR, {~modem_n, 4'h2});
    rdc(A_IDENT, 8'h01);
    wr(A_IEN, 8'h00);
    wr(A_IOIEN, 8'h01);
    @(posedge sys_clk);
    gpio_in[0] <= 1'b1;
    wait_clk(6);
    rdc(A_IDENT, 8'h30);
    rdc(A_IOSTATE, 8'h01);
    rdc(A_IDENT, 8'h01);
    wr(A_IEN, 8'h80);
    @(posedge sys_clk);
    modem_n[0] <= 1'b1;
    wait_clk(6);
    rdc(A_IDENT, 8'h20);
    rdc(A_MSR, {~modem_n, 4'h1});
    rdc(A_IDENT, 8'h01);
    wr(A_IEN, 8'h00);
  endtask

  // Sleep permission, entry conditions and wake-up by a transmit write, by receive line activity and by disabling sleep.
  task automatic t_sleep();
    wr(A_EFR, 8'h10);
    @(posedge sys_clk);
    ev[1] <= 1'b1;
    wr(A_IEN, 8'h10);
    wait_clk(8);
    chk("sleeping", 8'h00, {7'h00, sleeping});
    @(posedge sys_clk);
    ev[1] <= 1'b0;
    wait_clk(8);
    chk("sleeping", 8'h01, {7'h00, sleeping});
    chk("uart_clk_en", 8'h00, {7'h00, uart_clk_en});
    wr(A_HOLD, 8'h42);
    #1;
    chk("sleeping", 8'h00, {7'h00, sleeping});
    chk("tx_push", 8'h01, {7'h00, dp_out.tx_push});
    wait_clk(2);
    chk("sleeping", 8'h00, {7'h00, sleeping});
    wait_clk(10);
    chk("sleeping", 8'h01, {7'h00, sleeping});
    @(posedge sys_clk);
    rx_pin <= 1'b0;
    wait_clk(6);
    chk("sleeping", 8'h00, {7'h00, sleeping});
    rx_pin <= 1'b1;
    wait_clk(8);
    wr(A_IEN, 8'h00);
    wr(A_DLL, 8'h0c);
    wait_clk(3);
    chk("sleeping", 8'h00, {7'h00, sleeping});
    wr(A_EFR, 8'h00);
  endtask

  // Main sequence.
  initial begin
    wait_clk(5);
    srst <= 1'b0;
    wait_clk(1);
    t_check_reset();
    t_reset_sources();
    t_irq_prio();
    t_pin_events();
    t_sleep();
    close_out();
  end
endmodule

// ### tb/uirsc_dp_model.sv
// Behavioural model of the character datapath beside the control block.
`timescale 1ns/1ps
module uirsc_dp_model
  import uirsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [5:0] ev,
  input wire uirsc_dp_out_type dp_out,
  output uirsc_dp_in_type dp_in
);
  logic [2:0] busy_reg = 3'h0;

  // A pushed character keeps the transmitter busy for a few cycles.
  always_ff @(posedge sys_clk) begin
    if (dp_out.tx_fifo_clr) begin
      busy_reg <= 3'h0;
    end else if (dp_out.tx_push) begin
      busy_reg <= 3'h4;
    end else if (busy_reg != 3'h0) begin
      busy_reg <= busy_reg - 3'h1;
    end
  end

  // Status levels follow the bench knobs; pulses last as long as the knob.
  always_comb begin
    dp_in = '0;
    dp_in.rx_err_in_fifo = ev[0];
    dp_in.head_err = (ev[0] && ev[1]) ? 3'b010 : 3'b000;
    dp_in.rx_ready = ev[1];
    dp_in.rx_empty = !ev[1];
    dp_in.rx_timeout = ev[2];
    dp_in.thr_req = ev[3];
    dp_in.xoff_det = ev[4] && !ev[5];
    dp_in.xon_det = ev[5] && !ev[4];
    dp_in.special_det = ev[4] && ev[5];
    dp_in.tx_empty = busy_reg == 3'h0;
    dp_in.tx_shift_empty = busy_reg == 3'h0;
    dp_in.tx_bit = 1'b1;
    dp_in.rx_data = ev[1] ? 8'h5a : 8'ha5;
    dp_in.tx_level = (busy_reg == 3'h0) ? 8'h40 : 8'h3f;
    dp_in.rx_level = {7'h00, ev[1]};
  end
endmodule
